//--- src/swb_cfg.svh
// Offsets, field positions and reset patterns of the watchdog and bus control bank
`ifndef SWB_CFG_SVH
`define SWB_CFG_SVH
`define SWB_ADDR_HW 7'h02
`define SWB_ADDR_WD 7'h03
`define SWB_ADDR_BUS 7'h04
`define SWB_ADDR_PEAK 7'h05
`define SWB_HW_POR 8'h00
`define SWB_HW_SOFT_KEEP 8'h88
`define SWB_HW_RESTART_KEEP 8'hd9
`define SWB_HW_WMASK 8'hfb
`define SWB_HW_VSEL_BIT 7
`define SWB_HW_FO_BIT 5
`define SWB_HW_LS_BIT 3
`define SWB_WD_RST 8'h14
`define SWB_WD_RESTART_KEEP 8'hb0
`define SWB_WD_RESTART_SET 8'h04
`define SWB_WD_WMASK 8'hf7
`define SWB_WD_STOPDIS_BIT 6
`define SWB_WD_TYPE_BIT 5
`define SWB_WD_BUSWAKE_BIT 4
`define SWB_BUS_RST 8'h00
`define SWB_BUS_WMASK 8'h03
`define SWB_BUS_FAILSAFE 8'h01
`define SWB_PEAK_RST 8'h00
`define SWB_PEAK_WMASK 8'h20
`define SWB_PEAK_RESTART_KEEP 8'h20
`define SWB_PEAK_BIT 5
`define SWB_EXT_WAKE_FAILSAFE 8'h07
`define SWB_EXT_WAKE_KEEP 8'ha0
`endif

//--- src/swb_pkg.sv
// Types shared by the watchdog and bus control bank
package swb_pkg;
    typedef enum logic [3:0]
    {
        SWB_MODE_INIT = 4'h1,
        SWB_MODE_NORMAL = 4'h2,
        SWB_MODE_STOP = 4'h4,
        SWB_MODE_OTHER = 4'h8
    } swb_mode_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } swb_acc_t;

    typedef struct packed
    {
        logic soft_reset;
        logic restart_entry;
        logic failsafe_entry;
        logic failure_set;
        logic failure_clear;
        logic bus_wake;
        logic status_event;
        logic wake_event;
    } swb_evt_t;

    typedef struct packed
    {
        logic wd_run;
        logic wd_long_window;
        logic wd_type_select;
        logic [2:0] wd_period_select;
        logic [1:0] can_mode;
        logic supply_peak_threshold_select;
        logic aux_reg_voltage_select;
        logic aux_reg_load_share;
    } swb_ctl_t;

    typedef struct packed
    {
        logic [7:0] hw;
        logic [7:0] wd;
        logic [7:0] bus;
        logic [7:0] peak;
        logic fo;
        logic wd_run;
        logic long_win;
        logic [7:0] rdata;
        logic spi_fail;
        logic int_p;
        logic ewf;
    } swb_state_t;

    typedef struct packed
    {
        logic q;
    } swb_flag_t;
endpackage

//--- src/swb_flag_latch.sv
// Sticky flag where a set in the same cycle as a clear wins
`timescale 1ns/1ns
module swb_flag_latch
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic q_out
);
    import swb_pkg::*;
    swb_flag_t st;
    swb_flag_t next_st;

    always_comb
    begin
        next_st = st;
        if (set_in)
        begin
            next_st.q = 1'b1;
        end
        else if (clr_in)
        begin
            next_st.q = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q_out = st.q;
endmodule

//--- src/swb_parity.sv
// Odd-parity detector over a word
`timescale 1ns/1ns
module swb_parity
#(
    parameter int WIDTH = 8
)
(
    input wire logic [WIDTH-1:0] data_in,
    output logic odd_out
);
    logic [WIDTH-1:0] chain;

    if (WIDTH < 2)
    begin : g_bad
        $error("swb_parity needs at least two bits");
    end

    assign chain[0] = data_in[0];
    for (genvar i = 1; i < WIDTH; i++)
    begin : g_xor
        assign chain[i] = chain[i-1] ^ data_in[i];
    end
    assign odd_out = chain[WIDTH-1];
endmodule

//--- src/swb_regs.sv
// Watchdog, bus transceiver, peak threshold and supply control registers
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_regs
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire swb_pkg::swb_mode_t sbc_mode_in,
    input wire swb_pkg::swb_acc_t acc_in,
    input wire swb_pkg::swb_evt_t evt_in,
    input wire logic [1:0] restart_can_mode_in,
    input wire logic int_global_in,
    output logic [7:0] spi_rdata_out,
    output logic spi_fail_out,
    output logic int_out,
    output logic failure_outputs_out,
    output logic ext_wake_force_out,
    output swb_pkg::swb_ctl_t ctl_out
);
    import swb_pkg::*;

    swb_state_t st;
    swb_state_t next_st;
    logic fail_q;
    logic wake_hold_q;
    logic wd_odd;
    logic in_stop;
    logic peak_ok;
    logic any_evt;

    assign in_stop = (sbc_mode_in == SWB_MODE_STOP);
    assign peak_ok = (sbc_mode_in == SWB_MODE_INIT) || (sbc_mode_in == SWB_MODE_NORMAL);
    assign any_evt = evt_in.soft_reset || evt_in.restart_entry || evt_in.failsafe_entry;

    // Failure flag set by a detected failure, released only by its own clear
    swb_flag_latch u_fail
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .set_in(evt_in.failure_set),
        .clr_in(evt_in.failure_clear),
        .q_out(fail_q)
    );

    // Remembers a bus wake seen in stop until stop is left
    swb_flag_latch u_wake
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .set_in(evt_in.bus_wake && in_stop),
        .clr_in(!in_stop),
        .q_out(wake_hold_q)
    );

    swb_parity #(.WIDTH(8)) u_par
    (
        .data_in(acc_in.wdata),
        .odd_out(wd_odd)
    );

    always_comb
    begin
        next_st = st;
        next_st.spi_fail = 1'b0;
        next_st.ewf = 1'b0;
        next_st.long_win = 1'b0;
        if (evt_in.soft_reset)
        begin
            next_st.hw = st.hw & `SWB_HW_SOFT_KEEP;
            next_st.wd = `SWB_WD_RST;
            next_st.bus = `SWB_BUS_RST;
            next_st.peak = `SWB_PEAK_RST;
        end
        else if (evt_in.restart_entry)
        begin
            next_st.hw = st.hw & `SWB_HW_RESTART_KEEP;
            next_st.wd = (st.wd & `SWB_WD_RESTART_KEEP) | `SWB_WD_RESTART_SET;
            next_st.bus = {6'h00, restart_can_mode_in};
            next_st.peak = st.peak & `SWB_PEAK_RESTART_KEEP;
        end
        else if (evt_in.failsafe_entry)
        begin
            next_st.bus = `SWB_BUS_FAILSAFE;
            next_st.ewf = 1'b1;
        end
        else if (acc_in.wr)
        begin
            unique case (acc_in.addr)
                `SWB_ADDR_HW:
                begin
                    next_st.hw = acc_in.wdata & `SWB_HW_WMASK;
                end
                `SWB_ADDR_WD:
                begin
                    // Odd parity is refused whole so a corrupt period never lands
                    if (wd_odd)
                    begin
                        next_st.spi_fail = 1'b1;
                    end
                    else
                    begin
                        next_st.wd = acc_in.wdata & `SWB_WD_WMASK;
                    end
                end
                `SWB_ADDR_BUS:
                begin
                    next_st.bus = acc_in.wdata & `SWB_BUS_WMASK;
                end
                `SWB_ADDR_PEAK:
                begin
                    // Refused silently outside init and normal
                    if (peak_ok)
                    begin
                        next_st.peak = acc_in.wdata & `SWB_PEAK_WMASK;
                    end
                end
                default:
                begin
                    next_st.spi_fail = 1'b0;
                end
            endcase
        end
        // Failure outputs lag the failure flag by one cycle, the flag coming through its own latch
        next_st.fo = next_st.hw[`SWB_HW_FO_BIT] | fail_q;
        if (!in_stop)
        begin
            next_st.wd_run = 1'b1;
        end
        else if (wake_hold_q)
        begin
            next_st.wd_run = st.wd[`SWB_WD_BUSWAKE_BIT];
        end
        else
        begin
            next_st.wd_run = !st.wd[`SWB_WD_STOPDIS_BIT];
        end
        next_st.long_win = evt_in.bus_wake && in_stop
            && st.wd[`SWB_WD_BUSWAKE_BIT];
        next_st.int_p = evt_in.wake_event
            || (int_global_in && (evt_in.status_event || next_st.spi_fail));
        if (acc_in.rd || acc_in.wr)
        begin
            unique case (acc_in.addr)
                `SWB_ADDR_HW: next_st.rdata = st.hw;
                `SWB_ADDR_WD: next_st.rdata = st.wd;
                `SWB_ADDR_BUS: next_st.rdata = st.bus;
                `SWB_ADDR_PEAK: next_st.rdata = st.peak;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            st <= '0;
            st.hw <= `SWB_HW_POR;
            st.wd <= `SWB_WD_RST;
            st.bus <= `SWB_BUS_RST;
            st.peak <= `SWB_PEAK_RST;
            st.wd_run <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign spi_rdata_out = st.rdata;
    assign spi_fail_out = st.spi_fail;
    assign int_out = st.int_p;
    assign failure_outputs_out = st.fo;
    assign ext_wake_force_out = st.ewf;
    assign ctl_out.wd_run = st.wd_run;
    assign ctl_out.wd_long_window = st.long_win;
    assign ctl_out.wd_type_select = st.wd[`SWB_WD_TYPE_BIT];
    assign ctl_out.wd_period_select = st.wd[2:0];
    assign ctl_out.can_mode = st.bus[1:0];
    assign ctl_out.supply_peak_threshold_select = st.peak[`SWB_PEAK_BIT];
    assign ctl_out.aux_reg_voltage_select = st.hw[`SWB_HW_VSEL_BIT];
    assign ctl_out.aux_reg_load_share = st.hw[`SWB_HW_LS_BIT];

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    fail_hold_a: assert property (fail_q |=> st.fo)
        else $error("failure outputs dropped while failure flag set");
    restart_fo_a: assert property (evt_in.restart_entry && !evt_in.soft_reset && !fail_q
        |=> !st.fo && !st.hw[`SWB_HW_FO_BIT])
        else $error("restart left failure outputs on");
    soft_keep_a: assert property (evt_in.soft_reset
        |=> st.hw == ($past(st.hw) & `SWB_HW_SOFT_KEEP))
        else $error("soft reset pattern wrong in supply control");
    wd_restart_a: assert property (evt_in.restart_entry && !evt_in.soft_reset
        |=> st.wd == (($past(st.wd) & `SWB_WD_RESTART_KEEP) | `SWB_WD_RESTART_SET))
        else $error("watchdog restart pattern wrong");
    wd_parity_a: assert property (acc_in.wr && acc_in.addr == `SWB_ADDR_WD && !any_evt
        && wd_odd |=> st.spi_fail && $stable(st.wd))
        else $error("odd parity watchdog write accepted");
    wd_stop_a: assert property (in_stop && !wake_hold_q && st.wd[`SWB_WD_STOPDIS_BIT]
        ##1 in_stop |-> !st.wd_run)
        else $error("watchdog runs in stop while disabled");
    wake_start_a: assert property (evt_in.bus_wake && in_stop && st.wd[`SWB_WD_BUSWAKE_BIT]
        |=> st.long_win ##1 !st.long_win)
        else $error("no long window pulse after bus wake");
    reserved_zero_a: assert property (st.wd[3] == 1'b0 && st.bus[7:2] == 6'h00
        && (st.peak & ~`SWB_PEAK_WMASK) == 8'h00 && st.hw[2] == 1'b0)
        else $error("reserved bit set");
    failsafe_bus_a: assert property (evt_in.failsafe_entry && !evt_in.soft_reset
        && !evt_in.restart_entry |=> st.bus == `SWB_BUS_FAILSAFE && st.ewf)
        else $error("fail-safe pattern not forced");
    peak_stop_a: assert property (acc_in.wr && acc_in.addr == `SWB_ADDR_PEAK && in_stop
        && !any_evt |=> $stable(st.peak) && !st.spi_fail)
        else $error("peak bit changed or error raised in stop");
    int_gate_a: assert property (!int_global_in && !evt_in.wake_event |=> !st.int_p)
        else $error("interrupt from non-wake source");

    // Write landing, masked to the implemented bits
    hw_write_a: assert property (acc_in.wr && acc_in.addr == `SWB_ADDR_HW && !any_evt
        |=> st.hw == ($past(acc_in.wdata) & `SWB_HW_WMASK))
        else $error("supply control write did not land");
    wd_write_a: assert property (acc_in.wr && acc_in.addr == `SWB_ADDR_WD && !any_evt
        && !wd_odd |=> st.wd == ($past(acc_in.wdata) & `SWB_WD_WMASK))
        else $error("even parity watchdog write did not land");
    bus_write_a: assert property (acc_in.wr && acc_in.addr == `SWB_ADDR_BUS && !any_evt
        |=> st.bus == ($past(acc_in.wdata) & `SWB_BUS_WMASK))
        else $error("bus mode write did not land");
    peak_write_a: assert property (acc_in.wr && acc_in.addr == `SWB_ADDR_PEAK && peak_ok
        && !any_evt |=> st.peak == ($past(acc_in.wdata) & `SWB_PEAK_WMASK))
        else $error("peak write in init or normal did not land");

    // Run state of the watchdog
    wd_awake_a: assert property (!in_stop
        |=> st.wd_run)
        else $error("watchdog stopped outside stop mode");
    wake_run_a: assert property (in_stop && wake_hold_q
        |=> st.wd_run == $past(st.wd[`SWB_WD_BUSWAKE_BIT]))
        else $error("watchdog run state wrong after bus wake");
    long_win_a: assert property (!(evt_in.bus_wake && in_stop)
        |=> !st.long_win)
        else $error("long window without bus wake in stop");

    // Reset causes and mode entries
    wd_soft_a: assert property (evt_in.soft_reset
        |=> st.wd == `SWB_WD_RST)
        else $error("watchdog soft reset value wrong");
    hw_restart_a: assert property (evt_in.restart_entry && !evt_in.soft_reset
        |=> st.hw == ($past(st.hw) & `SWB_HW_RESTART_KEEP))
        else $error("supply control restart pattern wrong");
    bus_restart_a: assert property (evt_in.restart_entry && !evt_in.soft_reset
        |=> st.bus == {6'h00, $past(restart_can_mode_in)})
        else $error("bus mode restart value wrong");
    peak_restart_a: assert property (evt_in.restart_entry && !evt_in.soft_reset
        |=> st.peak == ($past(st.peak) & `SWB_PEAK_RESTART_KEEP))
        else $error("peak restart value wrong");
    ewf_only_a: assert property (!evt_in.failsafe_entry
        |=> !st.ewf)
        else $error("external wake forced without fail-safe entry");
    // Flag lags by a cycle, so outputs follow the flag seen one cycle earlier
    fo_track_a: assert property (st.fo == (st.hw[`SWB_HW_FO_BIT] || $past(fail_q)))
        else $error("failure outputs disagree with enable and flag");

    // Interrupt and error sources
    int_wake_a: assert property (evt_in.wake_event
        |=> st.int_p)
        else $error("wake source raised no interrupt");
    int_status_a: assert property (int_global_in && evt_in.status_event
        |=> st.int_p)
        else $error("status event raised no interrupt with global enable");
    spi_fail_only_a: assert property (!(acc_in.wr && acc_in.addr == `SWB_ADDR_WD)
        |=> !st.spi_fail)
        else $error("access error without watchdog write");

    // Read data shows the value from before the access
    rdata_bus_a: assert property (acc_in.rd && acc_in.addr == `SWB_ADDR_BUS
        |=> st.rdata == $past(st.bus))
        else $error("bus mode read data wrong");
    rdata_wd_a: assert property (acc_in.rd && acc_in.addr == `SWB_ADDR_WD
        |=> st.rdata == $past(st.wd))
        else $error("watchdog read data wrong");

    peak_write_c: cover property (acc_in.wr && acc_in.addr == `SWB_ADDR_PEAK && peak_ok);
    restart_fail_c: cover property (fail_q && evt_in.restart_entry);
    wake_long_c: cover property (st.long_win);
    failsafe_c: cover property (st.ewf);
    stop_wake_c: cover property (in_stop && wake_hold_q);
endmodule

//--- testbench/swb_host_model.sv
// Host model issuing register reads and writes with the watchdog checksum
`timescale 1ns/1ns
`include "swb_cfg.svh"
module swb_host_model
(
    input wire logic clk_sys_in,
    input wire logic [7:0] rdata_in,
    output swb_pkg::swb_acc_t acc_out
);
    import swb_pkg::*;
    initial acc_out = '0;
    // Raw write, no checksum; used on purpose to send odd parity
    task automatic write_raw(input logic [6:0] addr, input logic [7:0] data);
        @(posedge clk_sys_in);
        acc_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys_in);
        acc_out <= '0;
    endtask
    task automatic write(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == `SWB_ADDR_WD)
        begin
            d[7] = ^data[6:0];
        end
        write_raw(addr, d);
    endtask
    // Read data is registered at the taking edge
    task automatic read(input logic [6:0] addr, output logic [7:0] data);
        @(posedge clk_sys_in);
        acc_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_sys_in);
        acc_out <= '0;
        #1;
        data = rdata_in;
    endtask
endmodule

//--- testbench/test_sbc_watchdog_bus_control_regs.sv
// Self-checking bench for the watchdog and bus control bank
`timescale 1ns/1ns
`include "swb_cfg.svh"
module test_sbc_watchdog_bus_control_regs;
    import swb_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    swb_mode_t mode = SWB_MODE_INIT;
    swb_evt_t evt = '0;
    logic [1:0] rcan = 2'h2;
    logic glb = 1'b0;
    swb_acc_t acc;
    logic [7:0] rdata;
    logic fail;
    logic irq;
    logic fo;
    logic ewf;
    swb_ctl_t ctl;
    int failures = 0;
    int comparisons = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    swb_regs u_dut
    (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .sbc_mode_in(mode),
        .acc_in(acc),
        .evt_in(evt),
        .restart_can_mode_in(rcan),
        .int_global_in(glb),
        .spi_rdata_out(rdata),
        .spi_fail_out(fail),
        .int_out(irq),
        .failure_outputs_out(fo),
        .ext_wake_force_out(ewf),
        .ctl_out(ctl)
    );
    swb_host_model u_host
    (
        .clk_sys_in(clk_sys_in),
        .rdata_in(rdata),
        .acc_out(acc)
    );
    task automatic summarize;
        if (failures == 0 && comparisons > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.read(a, v);
        chk8(v, e);
    endtask
    task automatic step;
        @(posedge clk_sys_in);
        #1;
    endtask
    task automatic settle;
        step();
        step();
    endtask
    // Event bits: soft, restart, failsafe, fail set, fail clear, bus wake, status, wake
    task automatic pulse(input swb_evt_t e);
        @(posedge clk_sys_in);
        evt <= e;
        @(posedge clk_sys_in);
        evt <= '0;
        #1;
    endtask
    task automatic t_reset;
        rchk(`SWB_ADDR_HW, 8'h00);
        rchk(`SWB_ADDR_WD, 8'h14);
        rchk(`SWB_ADDR_BUS, 8'h00);
        rchk(`SWB_ADDR_PEAK, 8'h00);
        u_host.write(7'h10, 8'hff);
        rchk(7'h10, 8'h00);
    endtask
    task automatic t_bus;
        for (int m = 0; m < 4; m++)
        begin
            u_host.write(`SWB_ADDR_BUS, 8'hfc | 8'(m));
            rchk(`SWB_ADDR_BUS, 8'(m));
            chk8({6'h0, ctl.can_mode}, 8'(m));
        end
    endtask
    task automatic t_wd;
        u_host.write(`SWB_ADDR_WD, 8'h6d);
        rchk(`SWB_ADDR_WD, 8'he5);
        chk1(ctl.wd_type_select, 1'b1);
        u_host.write_raw(`SWB_ADDR_WD, 8'h01);
        #1;
        chk1(fail, 1'b1);
        rchk(`SWB_ADDR_WD, 8'he5);
        u_host.write(`SWB_ADDR_WD, 8'h45);
        rchk(`SWB_ADDR_WD, 8'hc5);
        chk1(ctl.wd_type_select, 1'b0);
    endtask
    // Stop with and without the disable bit, then bus wake both ways
    task automatic t_stop;
        u_host.write(`SWB_ADDR_WD, 8'h40);
        @(posedge clk_sys_in) mode <= SWB_MODE_STOP;
        settle();
        chk1(ctl.wd_run, 1'b0);
        @(posedge clk_sys_in) mode <= SWB_MODE_INIT;
        u_host.write(`SWB_ADDR_WD, 8'h00);
        @(posedge clk_sys_in) mode <= SWB_MODE_STOP;
        settle();
        chk1(ctl.wd_run, 1'b1);
        pulse(8'h04);
        settle();
        chk1(ctl.wd_run, 1'b0);
        @(posedge clk_sys_in) mode <= SWB_MODE_INIT;
        u_host.write(`SWB_ADDR_WD, 8'h50);
        @(posedge clk_sys_in) mode <= SWB_MODE_STOP;
        settle();
        chk1(ctl.wd_run, 1'b0);
        pulse(8'h04);
        chk1(ctl.wd_long_window, 1'b1);
        step();
        chk1(ctl.wd_run, 1'b1);
        @(posedge clk_sys_in) mode <= SWB_MODE_INIT;
    endtask
    task automatic t_peak;
        @(posedge clk_sys_in) mode <= SWB_MODE_NORMAL;
        glb <= 1'b1;
        u_host.write(`SWB_ADDR_PEAK, 8'hff);
        rchk(`SWB_ADDR_PEAK, 8'h20);
        chk1(ctl.supply_peak_threshold_select, 1'b1);
        @(posedge clk_sys_in) mode <= SWB_MODE_STOP;
        u_host.write(`SWB_ADDR_PEAK, 8'h00);
        #1;
        chk1(fail, 1'b0);
        chk1(irq, 1'b0);
        step();
        chk1(irq, 1'b0);
        rchk(`SWB_ADDR_PEAK, 8'h20);
        @(posedge clk_sys_in) mode <= SWB_MODE_OTHER;
        u_host.write(`SWB_ADDR_PEAK, 8'h00);
        rchk(`SWB_ADDR_PEAK, 8'h20);
        @(posedge clk_sys_in) mode <= SWB_MODE_INIT;
        glb <= 1'b0;
        u_host.write(`SWB_ADDR_PEAK, 8'h00);
        rchk(`SWB_ADDR_PEAK, 8'h00);
        chk1(ctl.supply_peak_threshold_select, 1'b0);
    endtask
    task automatic t_int;
        pulse(8'h02);
        chk1(irq, 1'b0);
        pulse(8'h01);
        chk1(irq, 1'b1);
        @(posedge clk_sys_in) glb <= 1'b1;
        pulse(8'h02);
        chk1(irq, 1'b1);
        @(posedge clk_sys_in) glb <= 1'b0;
    endtask
    task automatic t_fo;
        u_host.write(`SWB_ADDR_HW, 8'h20);
        settle();
        chk1(fo, 1'b1);
        pulse(8'h10);
        u_host.write(`SWB_ADDR_HW, 8'h00);
        settle();
        chk1(fo, 1'b1);
        pulse(8'h08);
        settle();
        chk1(fo, 1'b0);
        u_host.write(`SWB_ADDR_HW, 8'h20);
        pulse(8'h40);
        settle();
        chk1(fo, 1'b0);
        rchk(`SWB_ADDR_HW, 8'h00);
    endtask
    task automatic t_restart;
        u_host.write(`SWB_ADDR_WD, 8'h65);
        u_host.write(`SWB_ADDR_BUS, 8'h03);
        pulse(8'h40);
        rchk(`SWB_ADDR_WD, 8'h24);
        chk8({5'h0, ctl.wd_period_select}, 8'h04);
        rchk(`SWB_ADDR_BUS, 8'h02);
        @(posedge clk_sys_in) rcan <= 2'h1;
        pulse(8'h40);
        rchk(`SWB_ADDR_BUS, 8'h01);
    endtask
    task automatic t_soft;
        u_host.write(`SWB_ADDR_HW, 8'hff);
        rchk(`SWB_ADDR_HW, 8'hfb);
        pulse(8'h80);
        rchk(`SWB_ADDR_HW, 8'h88);
        chk1(ctl.aux_reg_voltage_select, 1'b1);
        chk1(ctl.aux_reg_load_share, 1'b1);
        rchk(`SWB_ADDR_WD, 8'h14);
        @(posedge clk_sys_in) rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rchk(`SWB_ADDR_HW, 8'h00);
        chk1(ctl.aux_reg_load_share, 1'b0);
    endtask
    task automatic t_failsafe;
        u_host.write(`SWB_ADDR_BUS, 8'h03);
        pulse(8'h20);
        chk1(ewf, 1'b1);
        rchk(`SWB_ADDR_BUS, 8'h01);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_reset();
        t_bus();
        t_wd();
        t_stop();
        t_peak();
        t_int();
        t_fo();
        t_restart();
        t_soft();
        t_failsafe();
        summarize();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        #200000;
        failures++;
        summarize();
    end
endmodule
